/* tmc_timer16_ctrl.sv */
// tmc_timer16_ctrl: 16-bit timer with mode decode, two compare outputs and capture
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: nonzero output mode routes channel to pin
// R2: pin driver enabled only with both override and direction bit
// R3: non-PWM: off, toggle, clear, set on match
// R4: fast PWM: 10 clear/bottom set, 11 inverse
// R5: PWM mode 01 toggles A only if top bit
// R6: dual-slope: 10 clear up, set down; 11 inverse
// R7: fast PWM compare at TOP ignored, bottom kept
// R8: mode is ctrl B 4:3 with ctrl A 1:0
// R9: mode 0 counts to 0xFFFF, immediate, overflow MAX
// R10: modes 4, 12 clear on match, immediate, MAX
// R11: phase correct tops; update TOP, overflow BOTTOM
// R12: fast PWM tops; update BOTTOM, overflow TOP
// R13: modes 8, 9 update and overflow at BOTTOM
// R14: noise filter needs four equal samples
// R15: edge select; capture copies counter, sets flag
// R16: capture disabled when capture value is TOP
// R17: clock select: stop, prescaled, external edges
// R18: mode 13 counts normally; reserved bits zero
module tmc_timer16_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  input wire logic external_count_pin,
  input wire logic ddr_out_a,
  input wire logic ddr_out_b,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic pin_override_a,
  output logic pin_override_b,
  output logic pin_drive_en_a,
  output logic pin_drive_en_b,
  output logic irq
);
  tmc_pkg::tmc_ctrl_a_t ctrl_a_reg, ctrl_a_next;
  tmc_pkg::tmc_ctrl_b_t ctrl_b_reg, ctrl_b_next;
  logic [15:0] cmp_buf_reg [2];
  logic [15:0] cmp_buf_next [2];
  logic [15:0] cmp_act_reg [2];
  logic [15:0] cmp_act_next [2];
  logic [15:0] capt_reg, capt_next, count_reg, count_next;
  logic dir_down_reg, dir_down_next, block_reg, block_next;
  logic [3:0] status_reg, status_next, enable_reg, enable_next;
  logic [9:0] presc_reg, presc_next;
  logic ext_prev_reg, ext_prev_next;
  logic [3:0] filt_shift_reg, filt_shift_next;
  logic filt_val_reg, filt_val_next, capt_prev_reg, capt_prev_next;
  logic [1:0] out_reg, out_next, ovr_reg, ovr_next, drv_reg, drv_next;
  logic irq_reg, irq_next, pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [3:0] wgm;
  tmc_pkg::tmc_wave_kind_t kind;
  tmc_pkg::tmc_top_src_t top_src;
  logic [15:0] top_fixed, top;
  logic tick, wrap_fast, upd_evt, ovf_evt, capt_edge, capt_evt;
  logic [1:0] com [2];
  logic raw_match [2];
  logic eff_match [2];
  logic out_calc [2];
  logic [7:0] idx;
  logic mapped, access, wr_en, cnt_wr;
  logic [3:0] set_flags, clr_flags;

  // mode decode, TOP and timer clock
  always_comb begin
    wgm = {ctrl_b_reg.wave_gen_mode_high, ctrl_a_reg.wave_gen_mode_low}; // see R8
    com[0] = ctrl_a_reg.chan_a_out_mode;
    com[1] = ctrl_a_reg.chan_b_out_mode;
    kind = tmc_pkg::WK_NORMAL;
    top_src = tmc_pkg::TS_FIXED;
    unique case (wgm)
      tmc_pkg::WGM_NORMAL, tmc_pkg::WGM_RESERVED: kind = tmc_pkg::WK_NORMAL; // see R9 see R18
      tmc_pkg::WGM_PC8, tmc_pkg::WGM_PC9, tmc_pkg::WGM_PC10: kind = tmc_pkg::WK_PHASE; // see R11
      tmc_pkg::WGM_CTC_CMP: begin
        kind = tmc_pkg::WK_CTC; // see R10
        top_src = tmc_pkg::TS_CMP_A;
      end
      tmc_pkg::WGM_FAST8, tmc_pkg::WGM_FAST9, tmc_pkg::WGM_FAST10: kind = tmc_pkg::WK_FAST; // see R12
      tmc_pkg::WGM_PFC_CAPT: begin
        kind = tmc_pkg::WK_PFC; // see R13
        top_src = tmc_pkg::TS_CAPT;
      end
      tmc_pkg::WGM_PFC_CMP: begin
        kind = tmc_pkg::WK_PFC; // see R13
        top_src = tmc_pkg::TS_CMP_A;
      end
      tmc_pkg::WGM_PC_CAPT: begin
        kind = tmc_pkg::WK_PHASE; // see R11
        top_src = tmc_pkg::TS_CAPT;
      end
      tmc_pkg::WGM_PC_CMP: begin
        kind = tmc_pkg::WK_PHASE; // see R11
        top_src = tmc_pkg::TS_CMP_A;
      end
      tmc_pkg::WGM_CTC_CAPT: begin
        kind = tmc_pkg::WK_CTC; // see R10
        top_src = tmc_pkg::TS_CAPT;
      end
      tmc_pkg::WGM_FAST_CAPT: begin
        kind = tmc_pkg::WK_FAST; // see R12
        top_src = tmc_pkg::TS_CAPT;
      end
      tmc_pkg::WGM_FAST_CMP: begin
        kind = tmc_pkg::WK_FAST; // see R12
        top_src = tmc_pkg::TS_CMP_A;
      end
    endcase
    unique case (wgm[1:0])
      2'h0: top_fixed = tmc_pkg::MAX_VALUE;
      2'h1: top_fixed = tmc_pkg::TOP_8BIT;
      2'h2: top_fixed = tmc_pkg::TOP_9BIT;
      2'h3: top_fixed = tmc_pkg::TOP_10BIT;
    endcase
    unique case (top_src)
      tmc_pkg::TS_CMP_A: top = cmp_act_reg[0];
      tmc_pkg::TS_CAPT: top = capt_reg;
      tmc_pkg::TS_FIXED: top = (kind == tmc_pkg::WK_NORMAL) ? tmc_pkg::MAX_VALUE : top_fixed;
    endcase
    unique case (ctrl_b_reg.clock_source_sel) // see R17
      tmc_pkg::CS_STOP: tick = 1'b0;
      tmc_pkg::CS_DIV1: tick = 1'b1;
      tmc_pkg::CS_DIV8: tick = (presc_reg & tmc_pkg::DIV8_MASK) == tmc_pkg::DIV8_MASK;
      tmc_pkg::CS_DIV64: tick = (presc_reg & tmc_pkg::DIV64_MASK) == tmc_pkg::DIV64_MASK;
      tmc_pkg::CS_DIV256: tick = (presc_reg & tmc_pkg::DIV256_MASK) == tmc_pkg::DIV256_MASK;
      tmc_pkg::CS_DIV1024: tick = presc_reg == tmc_pkg::DIV1024_MASK;
      tmc_pkg::CS_EXT_FALL: tick = ext_prev_reg & ~external_count_pin;
      tmc_pkg::CS_EXT_RISE: tick = ~ext_prev_reg & external_count_pin;
    endcase
  end

  // per-channel compare match and waveform action
  for (genvar i = 0; i < 2; i++) begin : g_chan
    always_comb begin
      raw_match[i] = tick & ~block_reg & (count_reg == cmp_act_reg[i]);
      // compare at TOP in fast PWM would fight the bottom action
      eff_match[i] = raw_match[i] & ~((kind == tmc_pkg::WK_FAST) & com[i][1]
                     & (cmp_act_reg[i] == top)); // see R7
      out_calc[i] = out_reg[i];
      if (kind == tmc_pkg::WK_NORMAL || kind == tmc_pkg::WK_CTC) begin
        if (eff_match[i]) begin
          unique case (com[i]) // see R3
            tmc_pkg::COM_OFF: out_calc[i] = out_reg[i];
            tmc_pkg::COM_TOGGLE: out_calc[i] = ~out_reg[i];
            tmc_pkg::COM_CLEAR: out_calc[i] = 1'b0;
            tmc_pkg::COM_SET: out_calc[i] = 1'b1;
          endcase
        end
      end else if (com[i] == tmc_pkg::COM_TOGGLE) begin
        if (eff_match[i] && wgm[3] && i == 0) begin
          out_calc[i] = ~out_reg[i]; // see R5
        end
      end else if (com[i][1]) begin
        if (kind == tmc_pkg::WK_FAST) begin
          if (eff_match[i]) begin
            out_calc[i] = com[i][0]; // see R4
          end else if (wrap_fast) begin
            out_calc[i] = ~com[i][0]; // see R4 see R7
          end
        end else if (eff_match[i]) begin
          out_calc[i] = com[i][0] ^ dir_down_reg; // see R6
        end
      end
    end
  end

  // next state of counter, capture, flags and bus
  always_comb begin
    count_next = count_reg;
    dir_down_next = 1'b0;
    upd_evt = 1'b0;
    ovf_evt = 1'b0;
    wrap_fast = 1'b0;
    if (tick) begin
      unique case (kind)
        tmc_pkg::WK_NORMAL: begin
          count_next = count_reg + 16'h0001;
          ovf_evt = count_reg == tmc_pkg::MAX_VALUE; // see R9
        end
        tmc_pkg::WK_CTC: begin
          count_next = (count_reg == top) ? tmc_pkg::VAL_RESET : count_reg + 16'h0001;
          ovf_evt = count_reg == tmc_pkg::MAX_VALUE; // see R10
        end
        tmc_pkg::WK_FAST: begin
          wrap_fast = count_reg >= top;
          count_next = wrap_fast ? tmc_pkg::VAL_RESET : count_reg + 16'h0001;
          ovf_evt = wrap_fast; // see R12
          upd_evt = wrap_fast;
        end
        tmc_pkg::WK_PHASE, tmc_pkg::WK_PFC: begin
          dir_down_next = dir_down_reg;
          if (!dir_down_reg && count_reg >= top) begin
            dir_down_next = 1'b1;
            count_next = count_reg - 16'h0001;
            upd_evt = kind == tmc_pkg::WK_PHASE; // see R11
          end else if (dir_down_reg && count_reg == tmc_pkg::VAL_RESET) begin
            dir_down_next = 1'b0;
            count_next = count_reg + 16'h0001;
            ovf_evt = 1'b1; // see R11 see R13
            upd_evt = kind == tmc_pkg::WK_PFC; // see R13
          end else begin
            count_next = dir_down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
          end
        end
      endcase
    end else if (kind == tmc_pkg::WK_PHASE || kind == tmc_pkg::WK_PFC) begin
      dir_down_next = dir_down_reg;
    end

    // apb decode; pready is registered so every access has one wait state
    idx = paddr[9:2];
    mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0)
             && (idx >= tmc_pkg::IDX_CTRL_B) && (idx <= tmc_pkg::IDX_ENABLE);
    access = psel & penable & ~pready_reg;
    pready_next = access;
    pslverr_next = access & ~mapped;
    wr_en = psel & penable & pwrite & pready_reg & ~pslverr_reg;
    cnt_wr = wr_en && idx == tmc_pkg::IDX_COUNT;
    prdata_next = 32'h0000_0000;
    if (access && !pwrite) begin
      case (idx)
        tmc_pkg::IDX_CTRL_B: prdata_next = {24'h00_0000, ctrl_b_reg}; // see R18
        tmc_pkg::IDX_CTRL_A: prdata_next = {24'h00_0000, ctrl_a_reg}; // see R18
        tmc_pkg::IDX_CMP_A: prdata_next = {16'h0000, cmp_buf_reg[0]};
        tmc_pkg::IDX_CMP_B: prdata_next = {16'h0000, cmp_buf_reg[1]};
        tmc_pkg::IDX_CAPT: prdata_next = {16'h0000, capt_reg};
        tmc_pkg::IDX_COUNT: prdata_next = {16'h0000, count_reg};
        tmc_pkg::IDX_STATUS: prdata_next = {28'h000_0000, status_reg};
        tmc_pkg::IDX_ENABLE: prdata_next = {28'h000_0000, enable_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    if (cnt_wr) begin
      count_next = pwdata[15:0];
    end
    // a counter write masks the match on the following timer clock
    block_next = cnt_wr ? 1'b1 : (tick ? 1'b0 : block_reg);
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    enable_next = enable_reg;
    if (wr_en && idx == tmc_pkg::IDX_CTRL_A) begin
      ctrl_a_next = pwdata[7:0] & tmc_pkg::CTRL_A_WMASK; // see R18
    end
    if (wr_en && idx == tmc_pkg::IDX_CTRL_B) begin
      ctrl_b_next = pwdata[7:0] & tmc_pkg::CTRL_B_WMASK; // see R18
    end
    if (wr_en && idx == tmc_pkg::IDX_ENABLE) begin
      enable_next = pwdata[3:0];
    end
    for (int k = 0; k < 2; k++) begin
      cmp_buf_next[k] = cmp_buf_reg[k];
      if (wr_en && idx == (k == 0 ? tmc_pkg::IDX_CMP_A : tmc_pkg::IDX_CMP_B)) begin
        cmp_buf_next[k] = pwdata[15:0];
      end
      if (kind == tmc_pkg::WK_NORMAL || kind == tmc_pkg::WK_CTC) begin
        cmp_act_next[k] = cmp_buf_next[k]; // see R9 see R10
      end else if (upd_evt) begin
        cmp_act_next[k] = cmp_buf_reg[k]; // see R11 see R12 see R13
      end else begin
        cmp_act_next[k] = cmp_act_reg[k];
      end
    end

    // capture path with optional four-sample filter
    filt_shift_next = {filt_shift_reg[2:0], capture_input_pin};
    if (ctrl_b_reg.capture_noise_filter_en) begin
      if (filt_shift_reg == tmc_pkg::FILT_ALL_HIGH) begin
        filt_val_next = 1'b1; // see R14
      end else if (filt_shift_reg == tmc_pkg::FILT_ALL_LOW) begin
        filt_val_next = 1'b0; // see R14
      end else begin
        filt_val_next = filt_val_reg;
      end
    end else begin
      filt_val_next = capture_input_pin;
    end
    capt_prev_next = filt_val_reg;
    capt_edge = ctrl_b_reg.capture_edge_sel ? (filt_val_reg & ~capt_prev_reg)
                                            : (~filt_val_reg & capt_prev_reg); // see R15
    capt_evt = capt_edge & (top_src != tmc_pkg::TS_CAPT); // see R16
    if (capt_evt) begin
      capt_next = count_reg; // see R15
    end else if (wr_en && idx == tmc_pkg::IDX_CAPT) begin
      capt_next = pwdata[15:0];
    end else begin
      capt_next = capt_reg;
    end

    // sticky flags: a set in the clearing cycle wins
    set_flags = tmc_pkg::FLAGS_RESET;
    set_flags[tmc_pkg::ST_OVF] = ovf_evt;
    set_flags[tmc_pkg::ST_CMP_A] = raw_match[0];
    set_flags[tmc_pkg::ST_CMP_B] = raw_match[1];
    set_flags[tmc_pkg::ST_CAPT] = capt_evt; // see R15
    clr_flags = (wr_en && idx == tmc_pkg::IDX_CLEAR) ? pwdata[3:0] : tmc_pkg::FLAGS_RESET;
    status_next = (status_reg & ~clr_flags) | set_flags;
    irq_next = |(status_next & enable_next);

    for (int k = 0; k < 2; k++) begin
      ovr_next[k] = |com[k]; // see R1
      // pwm toggle code drives a waveform only on channel a with the top mode bit set
      if (kind != tmc_pkg::WK_NORMAL && kind != tmc_pkg::WK_CTC
          && com[k] == tmc_pkg::COM_TOGGLE) begin
        ovr_next[k] = wgm[3] && k == 0; // see R5
      end
    end
    drv_next = ovr_next & {ddr_out_b, ddr_out_a}; // see R2
    out_next = {out_calc[1], out_calc[0]};
    presc_next = presc_reg + 10'h001;
    ext_prev_next = external_count_pin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_reg <= tmc_pkg::CTRL_A_RESET;
      ctrl_b_reg <= tmc_pkg::CTRL_B_RESET;
      for (int k = 0; k < 2; k++) begin
        cmp_buf_reg[k] <= tmc_pkg::VAL_RESET;
        cmp_act_reg[k] <= tmc_pkg::VAL_RESET;
      end
      capt_reg <= tmc_pkg::VAL_RESET;
      count_reg <= tmc_pkg::VAL_RESET;
      dir_down_reg <= 1'b0;
      block_reg <= 1'b0;
      status_reg <= tmc_pkg::FLAGS_RESET;
      enable_reg <= tmc_pkg::FLAGS_RESET;
      presc_reg <= tmc_pkg::PRESC_RESET;
      ext_prev_reg <= 1'b0;
      filt_shift_reg <= tmc_pkg::FILT_ALL_LOW;
      filt_val_reg <= 1'b0;
      capt_prev_reg <= 1'b0;
      out_reg <= 2'h0;
      ovr_reg <= 2'h0;
      drv_reg <= 2'h0;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      cmp_buf_reg <= cmp_buf_next;
      cmp_act_reg <= cmp_act_next;
      capt_reg <= capt_next;
      count_reg <= count_next;
      dir_down_reg <= dir_down_next;
      block_reg <= block_next;
      status_reg <= status_next;
      enable_reg <= enable_next;
      presc_reg <= presc_next;
      ext_prev_reg <= ext_prev_next;
      filt_shift_reg <= filt_shift_next;
      filt_val_reg <= filt_val_next;
      capt_prev_reg <= capt_prev_next;
      out_reg <= out_next;
      ovr_reg <= ovr_next;
      drv_reg <= drv_next;
      irq_reg <= irq_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign compare_out_a = out_reg[0];
  assign compare_out_b = out_reg[1];
  assign pin_override_a = ovr_reg[0];
  assign pin_override_b = ovr_reg[1];
  assign pin_drive_en_a = drv_reg[0];
  assign pin_drive_en_b = drv_reg[1];
  assign irq = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OVERRIDE_A: assert property (clk_en && com[0] != tmc_pkg::COM_OFF // see R1
    && (com[0][1] || wgm[3] || kind == tmc_pkg::WK_NORMAL || kind == tmc_pkg::WK_CTC)
    |=> pin_override_a)
    else $error("channel a not routed to pin");
  AST_DRIVE_NEEDS_OVERRIDE: assert property (pin_drive_en_b |-> pin_override_b && $past(ddr_out_b)) // see R2
    else $error("pin b driven without override and direction");
  AST_NONPWM_CLEAR: assert property (clk_en && kind == tmc_pkg::WK_CTC
    && com[0] == tmc_pkg::COM_CLEAR && eff_match[0] |=> !compare_out_a) // see R3
    else $error("clear on match failed");
  AST_FAST_BOTTOM_SET: assert property (clk_en && kind == tmc_pkg::WK_FAST
    && com[1] == tmc_pkg::COM_CLEAR && wrap_fast && !eff_match[1] |=> compare_out_b) // see R4
    else $error("fast pwm bottom set failed");
  AST_NORMAL_WRAP: assert property (clk_en && kind == tmc_pkg::WK_NORMAL && tick && !cnt_wr
    && count_reg == tmc_pkg::MAX_VALUE |=> count_reg == tmc_pkg::VAL_RESET
    && status_reg[tmc_pkg::ST_OVF]) // see R9
    else $error("normal mode wrap or overflow flag wrong");
  AST_PHASE_TURN: assert property (clk_en && kind == tmc_pkg::WK_PHASE && tick && !dir_down_reg
    && count_reg == top && !cnt_wr |=> dir_down_reg && count_reg == $past(count_reg) - 16'h0001) // see R11
    else $error("phase correct turn at top failed");
  AST_FILTER_FOUR: assert property (ctrl_b_reg.capture_noise_filter_en && clk_en
    && filt_val_next != filt_val_reg |-> filt_shift_reg inside {4'h0, 4'hf}) // see R14
    else $error("filter changed without four equal samples");
  AST_CAPTURE_COPY: assert property (clk_en && capt_evt
    |=> capt_reg == $past(count_reg) && status_reg[tmc_pkg::ST_CAPT]) // see R15
    else $error("capture copy or flag missing");
  AST_NO_CAPTURE_AT_TOP: assert property (clk_en && top_src == tmc_pkg::TS_CAPT
    && !status_reg[tmc_pkg::ST_CAPT] |=> !status_reg[tmc_pkg::ST_CAPT]) // see R16
    else $error("capture occurred while capture value is top");
  AST_STOPPED: assert property (clk_en && ctrl_b_reg.clock_source_sel == tmc_pkg::CS_STOP
    && !cnt_wr |=> count_reg == $past(count_reg)) // see R17
    else $error("counter moved while stopped");
  AST_RESERVED_ZERO: assert property (ctrl_a_reg.reserved == 2'h0 && !ctrl_b_reg.reserved) // see R18
    else $error("reserved control bits set");
endmodule // tmc_timer16_ctrl

`default_nettype wire

/* tmc_pkg.sv */
// tmc_pkg: constants and types of the 16-bit timer mode and compare output block
package tmc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL_B = 8'h2e;
  localparam logic [7:0] IDX_CTRL_A = 8'h2f;
  localparam logic [7:0] IDX_CMP_A = 8'h30;
  localparam logic [7:0] IDX_CMP_B = 8'h31;
  localparam logic [7:0] IDX_CAPT = 8'h32;
  localparam logic [7:0] IDX_COUNT = 8'h33;
  localparam logic [7:0] IDX_STATUS = 8'h34;
  localparam logic [7:0] IDX_CLEAR = 8'h35;
  localparam logic [7:0] IDX_ENABLE = 8'h36;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  localparam logic [15:0] MAX_VALUE = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [9:0] PRESC_RESET = 10'h000;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  // four successive equal samples
  localparam logic [3:0] FILT_ALL_HIGH = 4'hf;
  localparam logic [3:0] FILT_ALL_LOW = 4'h0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_CMP_A = 1;
  localparam int unsigned ST_CMP_B = 2;
  localparam int unsigned ST_CAPT = 3;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [3:0] WGM_NORMAL = 4'h0, WGM_PC8 = 4'h1, WGM_PC9 = 4'h2, WGM_PC10 = 4'h3,
    WGM_CTC_CMP = 4'h4, WGM_FAST8 = 4'h5, WGM_FAST9 = 4'h6, WGM_FAST10 = 4'h7,
    WGM_PFC_CAPT = 4'h8, WGM_PFC_CMP = 4'h9, WGM_PC_CAPT = 4'ha, WGM_PC_CMP = 4'hb,
    WGM_CTC_CAPT = 4'hc, WGM_RESERVED = 4'hd, WGM_FAST_CAPT = 4'he, WGM_FAST_CMP = 4'hf;
  typedef struct packed {
    logic [1:0] chan_a_out_mode;
    logic [1:0] chan_b_out_mode;
    logic [1:0] reserved;
    logic [1:0] wave_gen_mode_low;
  } tmc_ctrl_a_t;
  typedef struct packed {
    logic capture_noise_filter_en;
    logic capture_edge_sel;
    logic reserved;
    logic [1:0] wave_gen_mode_high;
    logic [2:0] clock_source_sel;
  } tmc_ctrl_b_t;
  typedef enum logic [2:0] {WK_NORMAL, WK_CTC, WK_FAST, WK_PHASE, WK_PFC} tmc_wave_kind_t;
  typedef enum logic [1:0] {TS_FIXED, TS_CMP_A, TS_CAPT} tmc_top_src_t;
endpackage

/* tmc_port_model.sv */
// tmc_port_model: behavioural i/o port pin beside one compare output
`timescale 1ns/1ps
`default_nettype none
module tmc_port_model (
  input wire logic compare_out,
  input wire logic pin_override,
  input wire logic pin_drive_en,
  input wire logic port_data,
  input wire logic ddr,
  output logic pin_level
);
  // an undriven pin floats up through the pull-up
  always_comb begin
    if (pin_override) begin
      pin_level = pin_drive_en ? compare_out : 1'b1;
    end else begin
      pin_level = ddr ? port_data : 1'b1;
    end
  end
endmodule // tmc_port_model
`default_nettype wire

/* tmc_timer16_ctrl_tb.sv */
// tmc_timer16_ctrl_tb: self-checking bench of the 16-bit timer block
`timescale 1ns/1ps
`default_nettype none
module tmc_timer16_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, capture_input_pin, perr, ext_pin;
  logic ddr_out_a, ddr_out_b, compare_out_a, compare_out_b, irq, pin_a, pin_b;
  logic pin_override_a, pin_override_b, pin_drive_en_a, pin_drive_en_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int checks, err_total, n, h, l;
  tmc_timer16_ctrl dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .capture_input_pin, .external_count_pin(ext_pin),
    .ddr_out_a, .ddr_out_b, .compare_out_a, .compare_out_b, .pin_override_a,
    .pin_override_b, .pin_drive_en_a, .pin_drive_en_b, .irq);
  tmc_port_model pa (.compare_out(compare_out_a), .pin_override(pin_override_a),
    .pin_drive_en(pin_drive_en_a), .port_data(1'b0), .ddr(ddr_out_a), .pin_level(pin_a));
  tmc_port_model pb (.compare_out(compare_out_b), .pin_override(pin_override_b),
    .pin_drive_en(pin_drive_en_b), .port_data(1'b0), .ddr(ddr_out_b), .pin_level(pin_b));
  always #50 pclk = ~pclk;
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  // two idle edges after each transfer let registered outputs settle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic w(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rc(input string s, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    chk(s, r, e);
  endtask
  task automatic wt(input logic ch, input logic v, output int c);
    c = 0;
    while ((ch ? compare_out_b : compare_out_a) !== v && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic run(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic t_regs;
    rc("ctrl_a rst", tmc_pkg::IDX_CTRL_A, 32'h0000_0000);
    rc("ctrl_b rst", tmc_pkg::IDX_CTRL_B, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_00ff);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_00ff);
    rc("ctrl_a rsv", tmc_pkg::IDX_CTRL_A, 32'h0000_00f3);
    rc("ctrl_b rsv", tmc_pkg::IDX_CTRL_B, 32'h0000_00df);
    w(8'h3f, 32'h0000_0000);
    chk("unmapped", {31'h0, perr}, 32'h0000_0001);
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0007);
    w(tmc_pkg::IDX_COUNT, 32'h0000_0000);
    repeat (5) begin
      ext_pin <= 1'b1;
      run(2);
      ext_pin <= 1'b0;
      run(2);
    end
    rc("ext count", tmc_pkg::IDX_COUNT, 32'h0000_0005);
    $display("register test done");
  endtask
  task automatic t_normal;
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_0040);
    w(tmc_pkg::IDX_CMP_A, 32'h0000_fff8);
    w(tmc_pkg::IDX_COUNT, 32'h0000_fff0);
    w(tmc_pkg::IDX_CLEAR, 32'h0000_000f);
    w(tmc_pkg::IDX_ENABLE, 32'h0000_0003);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0001);
    run(30);
    chk("override a", pin_override_a, 1);
    chk("toggle a", compare_out_a, 1);
    chk("irq", irq, 1);
    rc("flags", tmc_pkg::IDX_STATUS, 32'h0000_0007);
    w(tmc_pkg::IDX_ENABLE, 32'h0000_0000);
    chk("irq masked", irq, 0);
    w(tmc_pkg::IDX_CLEAR, 32'h0000_0007);
    rc("flags clr", tmc_pkg::IDX_STATUS, 32'h0000_0000);
    for (int m = 2; m < 4; m++) begin
      w(tmc_pkg::IDX_CTRL_A, 32'(m) << 6);
      w(tmc_pkg::IDX_COUNT, 32'h0000_fff0);
      run(30);
      chk("clear set a", compare_out_a, 32'(m == 3));
    end
    chk("pin a float", pin_a, 1);
    ddr_out_a <= 1'b1;
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_0080);
    w(tmc_pkg::IDX_COUNT, 32'h0000_fff0);
    run(30);
    chk("pin a driven", pin_a, 0);
    $display("normal test done");
  endtask
  task automatic t_fast;
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_0021);
    w(tmc_pkg::IDX_CMP_B, 32'h0000_0010);
    w(tmc_pkg::IDX_CLEAR, 32'h0000_000f);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0009);
    wt(1, 0, n);
    wt(1, 1, n);
    wt(1, 0, h);
    wt(1, 1, l);
    chk("fast high", h, 17);
    chk("fast low", l, 239);
    chk("override a off", pin_override_a, 0);
    rc("fast flags", tmc_pkg::IDX_STATUS, 32'h0000_0005);
    w(tmc_pkg::IDX_CMP_B, 32'h0000_00ff);
    run(300);
    l = 0;
    repeat (600) begin
      @(posedge pclk);
      if (compare_out_b !== 1'b1) l++;
    end
    chk("top match", l, 0);
    $display("fast pwm test done");
  endtask
  task automatic t_phase;
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_00d1);
    w(tmc_pkg::IDX_CMP_A, 32'h0000_0040);
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0001);
    wt(0, 0, n);
    wt(0, 1, n);
    wt(0, 0, h);
    wt(0, 1, l);
    chk("dual high", h, 382);
    chk("dual low", l, 128);
    chk("override b off", pin_override_b, 0);
    $display("phase correct test done");
  endtask
  task automatic cap(input logic [31:0] ctl, input logic v, input int c, input logic f);
    w(tmc_pkg::IDX_CTRL_B, ctl);
    w(tmc_pkg::IDX_CLEAR, 32'h0000_0008);
    capture_input_pin <= v;
    run(c);
    capture_input_pin <= 1'b1;
    run(12);
    apb(1'b0, tmc_pkg::IDX_STATUS, 32'h0000_0000);
    chk("capture flag", r[3], 32'(f));
  endtask
  task automatic t_capture;
    w(tmc_pkg::IDX_CTRL_B, 32'h0000_0000);
    w(tmc_pkg::IDX_CTRL_A, 32'h0000_0000);
    w(tmc_pkg::IDX_COUNT, 32'h0000_1234);
    w(tmc_pkg::IDX_ENABLE, 32'h0000_0008);
    cap(32'h0000_0040, 1'b1, 1, 1'b1);
    rc("capture", tmc_pkg::IDX_CAPT, 32'h0000_1234);
    chk("irq capture", irq, 1);
    cap(32'h0000_00c0, 1'b0, 12, 1'b1);
    w(tmc_pkg::IDX_CLEAR, 32'h0000_0008);
    capture_input_pin <= 1'b1;
    run(8);
    cap(32'h0000_00c0, 1'b0, 3, 1'b0);
    w(tmc_pkg::IDX_COUNT, 32'h0000_0abc);
    cap(32'h0000_0000, 1'b0, 12, 1'b1);
    rc("capture fall", tmc_pkg::IDX_CAPT, 32'h0000_0abc);
    cap(32'h0000_0018, 1'b0, 12, 1'b0);
    $display("capture test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, capture_input_pin, ddr_out_a, ddr_out_b, ext_pin} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    run(8);
    presetn <= 1'b1;
    run(1);
    t_regs();
    t_normal();
    t_fast();
    t_phase();
    t_capture();
    final_report();
  end
  initial begin
    #4_000_000;
    err_total++;
    final_report();
  end
endmodule // tmc_timer16_ctrl_tb
`default_nettype wire
